/* File: rtl/pch_pkg.sv */
// Constants and carrier types for the configuration header register bank
package pch_pkg;
  localparam logic [7:0]  OFS_HOLD       = 8'h0d;
  localparam logic [7:0]  OFS_LAYOUT     = 8'h0e;
  localparam logic [7:0]  OFS_SELFTEST   = 8'h0f;
  localparam logic [7:0]  OFS_OPBASE     = 8'h10;
  localparam logic [7:0]  OFS_SUB_MAKER  = 8'h2c;
  localparam logic [7:0]  OFS_SUB_TYPE   = 8'h2e;
  localparam logic [7:0]  OFS_ROM        = 8'h30;
  localparam logic [7:0]  OFS_CAP_PTR    = 8'h34;
  localparam logic [7:0]  OFS_IRQ_LINE   = 8'h3c;
  localparam logic [7:0]  OFS_IRQ_PIN    = 8'h3d;
  localparam logic [7:0]  OFS_BURST      = 8'h3e;
  localparam logic [7:0]  OFS_INTERVAL   = 8'h3f;
  localparam logic [7:0]  OFS_BYTE_ORDER = 8'h40;

  localparam logic [7:0]  RST_HOLD       = 8'h00;
  localparam logic [7:0]  VAL_LAYOUT     = 8'h00;
  localparam logic [7:0]  VAL_SELFTEST   = 8'h00;
  localparam logic [11:0] VAL_OPBASE_LOW = 12'h000;
  localparam logic [31:0] VAL_ROM        = 32'h0000_0000;
  localparam logic [7:0]  VAL_CAP_PTR    = 8'h60;
  localparam logic [7:0]  RST_IRQ_LINE   = 8'h00;
  localparam logic [7:0]  VAL_IRQ_PIN    = 8'h01;
  localparam logic [7:0]  RST_BURST      = 8'h00;
  localparam logic [7:0]  RST_INTERVAL   = 8'h00;
  localparam logic [15:0] RST_SUB_CODE   = 16'h0000;
  localparam logic [19:0] RST_OPBASE     = 20'h00000;
  localparam int          SWAP_BIT       = 0;
  localparam logic        RST_SWAP       = 1'b0;
  localparam int          OPBASE_LSB     = 12;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [5:0]  dword;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pch_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pch_mem_req_t;

  typedef struct packed {
    logic [15:0] maker;
    logic [15:0] kind;
    logic [7:0]  burst;
    logic [7:0]  interval;
  } pch_load_t;
endpackage

/* File: rtl/pch_swap.sv */
// Registered quadlet byte swapper with pass-through valid
module pch_swap (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        in_valid,
  input  wire logic        swap,
  input  wire logic [31:0] in_data,
  input  wire logic [3:0]  in_be,
  output logic             out_valid_ff,
  output logic [31:0]      out_data_ff,
  output logic [3:0]       out_be_ff
);
  logic        nxt_out_valid;
  logic [31:0] nxt_out_data;
  logic [3:0]  nxt_out_be;

  always_comb begin
    nxt_out_valid = in_valid;
    nxt_out_data  = in_data;
    nxt_out_be    = in_be;
    if (swap) begin
      nxt_out_data = {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]};
      nxt_out_be   = {in_be[0], in_be[1], in_be[2], in_be[3]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= 32'h0000_0000;
      out_be_ff    <= 4'h0;
    end else begin
      out_valid_ff <= nxt_out_valid;
      out_data_ff  <= nxt_out_data;
      out_be_ff    <= nxt_out_be;
    end
  end
endmodule

/* File: rtl/pch_cfg_regs.sv */
// Upper configuration header registers, operational window decode and global swap
module pch_cfg_regs #(
  parameter int WIN_BITS = 12
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire pch_pkg::pch_cfg_req_t cfg_req,
  input  wire pch_pkg::pch_mem_req_t mem_req,
  input  wire logic                  load_valid,
  input  wire pch_pkg::pch_load_t    load_data,
  input  wire logic                  op_rvalid,
  input  wire logic [31:0]           op_rdata,
  output logic                       cfg_ack_ff,
  output logic [31:0]                cfg_rdata_ff,
  output logic                       mem_hit_ff,
  output logic                       op_req_ff,
  output logic                       op_we_ff,
  output logic [11:0]                op_addr_ff,
  output logic [31:0]                op_wdata_ff,
  output logic [3:0]                 op_be_ff,
  output logic                       mem_rvalid_ff,
  output logic [31:0]                mem_rdata_ff,
  output logic [7:0]                 bus_hold_limit_ff,
  output logic [7:0]                 irq_routing_line_ff,
  output logic                       swap_en_ff,
  output logic                       load_done_ff
);
  // The window size is tied to the fixed low base field
  if (WIN_BITS != pch_pkg::OPBASE_LSB) begin
    $error("WIN_BITS must match the fixed low base field");
  end

  // Read words pack neighbouring bytes by lane, so the package offsets must keep this layout
  if (pch_pkg::OFS_HOLD[1:0] != 2'h1) begin
    $error("Hold limit byte must sit in lane one");
  end
  if (pch_pkg::OFS_LAYOUT != pch_pkg::OFS_HOLD + 8'h01) begin
    $error("Header layout byte must follow the hold limit byte");
  end
  if (pch_pkg::OFS_SELFTEST != pch_pkg::OFS_HOLD + 8'h02) begin
    $error("Self-test byte must sit two lanes above the hold limit byte");
  end
  if (pch_pkg::OFS_OPBASE[1:0] != 2'h0) begin
    $error("Window base must be dword aligned");
  end
  if (pch_pkg::OFS_SUB_MAKER[1:0] != 2'h0) begin
    $error("Subsystem maker code must be dword aligned");
  end
  if (pch_pkg::OFS_SUB_TYPE != pch_pkg::OFS_SUB_MAKER + 8'h02) begin
    $error("Subsystem type code must follow the maker code");
  end
  if (pch_pkg::OFS_ROM[1:0] != 2'h0) begin
    $error("Expansion ROM base must be dword aligned");
  end
  if (pch_pkg::OFS_CAP_PTR[1:0] != 2'h0) begin
    $error("Capability pointer byte must sit in lane zero");
  end
  if (pch_pkg::VAL_CAP_PTR[1:0] != 2'h0) begin
    $error("Capability pointer must name a dword aligned entry");
  end
  if (pch_pkg::OFS_IRQ_LINE[1:0] != 2'h0) begin
    $error("Interrupt routing byte must sit in lane zero");
  end
  if (pch_pkg::OFS_IRQ_PIN != pch_pkg::OFS_IRQ_LINE + 8'h01) begin
    $error("Interrupt pin byte must follow the routing byte");
  end
  if (pch_pkg::OFS_BURST != pch_pkg::OFS_IRQ_LINE + 8'h02) begin
    $error("Burst-need byte must sit in lane two of the interrupt word");
  end
  if (pch_pkg::OFS_INTERVAL != pch_pkg::OFS_IRQ_LINE + 8'h03) begin
    $error("Access-interval byte must sit in lane three of the interrupt word");
  end
  if (pch_pkg::OFS_BYTE_ORDER[1:0] != 2'h0) begin
    $error("Byte order control must be dword aligned");
  end
  if (pch_pkg::SWAP_BIT != 0) begin
    $error("Swap bit must be bit zero of the control word");
  end

  localparam logic [5:0] DW_HOLD  = pch_pkg::OFS_HOLD[7:2];
  localparam logic [5:0] DW_BASE  = pch_pkg::OFS_OPBASE[7:2];
  localparam logic [5:0] DW_SUB   = pch_pkg::OFS_SUB_MAKER[7:2];
  localparam logic [5:0] DW_ROM   = pch_pkg::OFS_ROM[7:2];
  localparam logic [5:0] DW_CAP   = pch_pkg::OFS_CAP_PTR[7:2];
  localparam logic [5:0] DW_IRQ   = pch_pkg::OFS_IRQ_LINE[7:2];
  localparam logic [5:0] DW_ORDER = pch_pkg::OFS_BYTE_ORDER[7:2];

  logic [19:0] op_base_ff;
  logic [15:0] subsys_maker_code_ff;
  logic [15:0] subsys_type_code_ff;
  logic [7:0]  burst_need_ff;
  logic [7:0]  access_interval_need_ff;
  logic        mem_we_ff;
  logic        mem_rd_pend_ff;

  logic [7:0]  nxt_bus_hold_limit;
  logic [7:0]  nxt_irq_routing_line;
  logic        nxt_swap_en;
  logic [19:0] nxt_op_base;
  logic [15:0] nxt_subsys_maker_code;
  logic [15:0] nxt_subsys_type_code;
  logic [7:0]  nxt_burst_need;
  logic [7:0]  nxt_access_interval_need;
  logic        nxt_load_done;
  logic        nxt_cfg_ack;
  logic [31:0] nxt_cfg_rdata;
  logic        nxt_mem_hit;
  logic        nxt_mem_we;
  logic [11:0] nxt_op_addr;
  logic        nxt_mem_rd_pend;
  logic        cfg_wr;
  logic        win_match;

  logic        wr_valid;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;
  logic        rd_valid;
  logic [31:0] rd_data;

  // Host-writable bytes; configuration data is used as it arrives, never through the swapper
  always_comb begin
    nxt_bus_hold_limit   = bus_hold_limit_ff;
    nxt_irq_routing_line = irq_routing_line_ff;
    nxt_swap_en          = swap_en_ff;
    nxt_op_base          = op_base_ff;
    cfg_wr               = cfg_req.valid && cfg_req.we;
    if (cfg_wr) begin
      unique case (cfg_req.dword)
        DW_HOLD: begin
          if (cfg_req.be[1]) nxt_bus_hold_limit = cfg_req.wdata[15:8];
        end
        // Lane zero of the base word holds the fixed low bits, so it has no enable
        DW_BASE: begin
          if (cfg_req.be[1]) nxt_op_base[3:0]   = cfg_req.wdata[15:12];
          if (cfg_req.be[2]) nxt_op_base[11:4]  = cfg_req.wdata[23:16];
          if (cfg_req.be[3]) nxt_op_base[19:12] = cfg_req.wdata[31:24];
        end
        DW_IRQ: begin
          if (cfg_req.be[0]) nxt_irq_routing_line = cfg_req.wdata[7:0];
        end
        DW_ORDER: begin
          if (cfg_req.be[0]) nxt_swap_en = cfg_req.wdata[pch_pkg::SWAP_BIT];
        end
        default: begin
          // Constant and loaded bytes ignore writes
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_hold_limit_ff   <= pch_pkg::RST_HOLD;
      irq_routing_line_ff <= pch_pkg::RST_IRQ_LINE;
      swap_en_ff          <= pch_pkg::RST_SWAP;
      op_base_ff          <= pch_pkg::RST_OPBASE;
    end else begin
      bus_hold_limit_ff   <= nxt_bus_hold_limit;
      irq_routing_line_ff <= nxt_irq_routing_line;
      swap_en_ff          <= nxt_swap_en;
      op_base_ff          <= nxt_op_base;
    end
  end

  // Serial-memory identity and bus-timing bytes
  always_comb begin
    nxt_subsys_maker_code    = subsys_maker_code_ff;
    nxt_subsys_type_code     = subsys_type_code_ff;
    nxt_burst_need           = burst_need_ff;
    nxt_access_interval_need = access_interval_need_ff;
    nxt_load_done            = load_done_ff;
    // Only the first load after reset is taken, so a stray strobe cannot rewrite identity
    if (load_valid && !load_done_ff) begin
      nxt_subsys_maker_code    = load_data.maker;
      nxt_subsys_type_code     = load_data.kind;
      nxt_burst_need           = load_data.burst;
      nxt_access_interval_need = load_data.interval;
      nxt_load_done            = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      subsys_maker_code_ff    <= pch_pkg::RST_SUB_CODE;
      subsys_type_code_ff     <= pch_pkg::RST_SUB_CODE;
      burst_need_ff           <= pch_pkg::RST_BURST;
      access_interval_need_ff <= pch_pkg::RST_INTERVAL;
      load_done_ff            <= 1'b0;
    end else begin
      subsys_maker_code_ff    <= nxt_subsys_maker_code;
      subsys_type_code_ff     <= nxt_subsys_type_code;
      burst_need_ff           <= nxt_burst_need;
      access_interval_need_ff <= nxt_access_interval_need;
      load_done_ff            <= nxt_load_done;
    end
  end

  // Acknowledge and read answer, one cycle after the request
  always_comb begin
    nxt_cfg_ack   = cfg_req.valid;
    nxt_cfg_rdata = 32'h0000_0000;
    if (cfg_req.valid && !cfg_req.we) begin
      // Unmapped dwords read zero but are still acknowledged
      unique case (cfg_req.dword)
        DW_HOLD:  nxt_cfg_rdata = {pch_pkg::VAL_SELFTEST, pch_pkg::VAL_LAYOUT,
                                   bus_hold_limit_ff, 8'h00};
        DW_BASE:  nxt_cfg_rdata = {op_base_ff, pch_pkg::VAL_OPBASE_LOW};
        DW_SUB:   nxt_cfg_rdata = {subsys_type_code_ff, subsys_maker_code_ff};
        DW_ROM:   nxt_cfg_rdata = pch_pkg::VAL_ROM;
        DW_CAP:   nxt_cfg_rdata = {24'h000000, pch_pkg::VAL_CAP_PTR};
        DW_IRQ:   nxt_cfg_rdata = {access_interval_need_ff, burst_need_ff,
                                   pch_pkg::VAL_IRQ_PIN, irq_routing_line_ff};
        DW_ORDER: nxt_cfg_rdata = {31'h0000_0000, swap_en_ff};
        default:  nxt_cfg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ack_ff   <= 1'b0;
      cfg_rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ack_ff   <= nxt_cfg_ack;
      cfg_rdata_ff <= nxt_cfg_rdata;
    end
  end

  // Window decode; one pending flag, so a second read before the answer is not queued
  always_comb begin
    win_match       = mem_req.addr[31:pch_pkg::OPBASE_LSB] == op_base_ff;
    nxt_mem_hit     = mem_req.valid && win_match;
    nxt_mem_we      = mem_req.we;
    nxt_op_addr     = mem_req.addr[11:0];
    nxt_mem_rd_pend = mem_rd_pend_ff;
    if (nxt_mem_hit && !mem_req.we) nxt_mem_rd_pend = 1'b1;
    else if (op_rvalid) nxt_mem_rd_pend = 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_hit_ff     <= 1'b0;
      mem_we_ff      <= 1'b0;
      op_addr_ff     <= 12'h000;
      mem_rd_pend_ff <= 1'b0;
    end else begin
      mem_hit_ff     <= nxt_mem_hit;
      mem_we_ff      <= nxt_mem_we;
      op_addr_ff     <= nxt_op_addr;
      mem_rd_pend_ff <= nxt_mem_rd_pend;
    end
  end

  assign op_we_ff  = mem_we_ff;
  // The forward strobe is the swapper's registered valid, so it lines up with data and lanes

  // Write path: claimed memory quadlets pass the swapper on the way in
  assign wr_valid  = nxt_mem_hit;
  assign wr_data   = mem_req.wdata;
  assign wr_be     = mem_req.be;

  pch_swap u_wr_swap (
    .clk          (clk),
    .resetn       (resetn),
    .in_valid     (wr_valid),
    .swap         (swap_en_ff),
    .in_data      (wr_data),
    .in_be        (wr_be),
    .out_valid_ff (op_req_ff),
    .out_data_ff  (op_wdata_ff),
    .out_be_ff    (op_be_ff)
  );

  // Read path: returned quadlets are swapped again toward the bus
  assign rd_valid = op_rvalid && mem_rd_pend_ff;
  assign rd_data  = op_rdata;

  pch_swap u_rd_swap (
    .clk          (clk),
    .resetn       (resetn),
    .in_valid     (rd_valid),
    .swap         (swap_en_ff),
    .in_data      (rd_data),
    .in_be        (4'hf),
    .out_valid_ff (mem_rvalid_ff),
    .out_data_ff  (mem_rdata_ff),
    .out_be_ff    ()
  );
endmodule

/* File: verif/pch_cfg_regs_props.sv */
// Port assertions for the configuration header register bank
module pch_cfg_regs_props (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire pch_pkg::pch_cfg_req_t cfg_req,
  input wire pch_pkg::pch_mem_req_t mem_req,
  input wire logic                  cfg_ack_ff,
  input wire logic [31:0]           cfg_rdata_ff,
  input wire logic                  mem_hit_ff,
  input wire logic                  op_req_ff,
  input wire logic [11:0]           op_addr_ff,
  input wire logic [7:0]            bus_hold_limit_ff,
  input wire logic [7:0]            irq_routing_line_ff,
  input wire logic                  swap_en_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd;
  logic wr;
  assign rd = cfg_req.valid && !cfg_req.we;
  assign wr = cfg_req.valid && cfg_req.we;
  a_ack_one_cycle: assert property (cfg_req.valid |=> cfg_ack_ff ##1 !cfg_ack_ff || $past(cfg_req.valid))
    else $error("config ack missing or stuck");
  a_hold_write: assert property (wr && cfg_req.dword == 6'h03 && cfg_req.be[1]
    |=> bus_hold_limit_ff == $past(cfg_req.wdata[15:8])) else $error("hold limit not written");
  a_line_write: assert property (wr && cfg_req.dword == 6'h0f && cfg_req.be[0]
    |=> irq_routing_line_ff == $past(cfg_req.wdata[7:0])) else $error("routing line not written");
  a_swap_write: assert property (wr && cfg_req.dword == 6'h10 && cfg_req.be[0]
    |=> swap_en_ff == $past(cfg_req.wdata[0])) else $error("swap bit not written");
  a_layout_zero: assert property (rd && cfg_req.dword == 6'h03 |=> cfg_rdata_ff[31:16] == 16'h0)
    else $error("layout or self test byte nonzero");
  a_base_low_zero: assert property (rd && cfg_req.dword == 6'h04 |=> cfg_rdata_ff[11:0] == 12'h0)
    else $error("window base low bits nonzero");
  a_rom_zero: assert property (rd && cfg_req.dword == 6'h0c |=> cfg_rdata_ff == 32'h0)
    else $error("rom base nonzero");
  a_cap_ptr: assert property (rd && cfg_req.dword == 6'h0d |=> cfg_rdata_ff == 32'h60)
    else $error("capability pointer wrong");
  a_pin_one: assert property (rd && cfg_req.dword == 6'h0f |=> cfg_rdata_ff[15:8] == 8'h01)
    else $error("interrupt pin byte wrong");
  a_ctl_reserved: assert property (rd && cfg_req.dword == 6'h10
    |=> cfg_rdata_ff == {31'h0, swap_en_ff}) else $error("control reserved bits nonzero");
  a_hit_forward: assert property (mem_hit_ff |-> op_req_ff && $past(mem_req.valid)
    && op_addr_ff == $past(mem_req.addr[11:0])) else $error("claimed access not forwarded");
endmodule

bind pch_cfg_regs pch_cfg_regs_props u_props (.*);

/* File: verif/pch_op_model.sv */
// Behavioural operational register space answering forwarded window accesses
module pch_op_model (
  input wire logic        clk,
  input wire logic        slow,
  input wire logic        op_req_ff,
  input wire logic        op_we_ff,
  input wire logic [11:0] op_addr_ff,
  input wire logic [31:0] op_wdata_ff,
  input wire logic [3:0]  op_be_ff,
  output logic            op_rvalid,
  output logic [31:0]     op_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [4];
  logic [1:0]  ix;
  initial begin
    op_rvalid = 1'h0;
    op_rdata = 32'h5a5a_a5a5;
    foreach (mem[i]) mem[i] = 32'h0;
    forever begin
      @(posedge clk);
      ix = op_addr_ff[3:2];
      if (op_req_ff && op_we_ff) begin
        for (int b = 0; b < 4; b++) if (op_be_ff[b]) mem[ix][8*b +: 8] = op_wdata_ff[8*b +: 8];
      end else if (op_req_ff) begin
        // Slow answers check that the read stays pending in the bank
        if (slow) repeat (3) @(posedge clk);
        #1 op_rvalid = 1'h1;
        op_rdata = mem[ix];
        @(posedge clk);
        #1 op_rvalid = 1'h0;
        // Stale data is inverted so it never passes for a fresh answer
        op_rdata = ~op_rdata;
      end
    end
  end
endmodule

/* File: verif/pch_cfg_regs_bench.sv */
// Self-checking bench for the configuration header register bank
module pch_cfg_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        we;
    logic [5:0]  dw;
    logic [31:0] wd;
    logic [31:0] ex;
  } pch_row_t;
  logic                  clk, resetn, load_valid, op_rvalid, slow;
  pch_pkg::pch_cfg_req_t cfg_req;
  pch_pkg::pch_mem_req_t mem_req;
  pch_pkg::pch_load_t    load_data;
  logic [31:0]           op_rdata, cfg_rdata_ff, op_wdata_ff, mem_rdata_ff, r;
  logic [11:0]           op_addr_ff;
  logic [7:0]            bus_hold_limit_ff, irq_routing_line_ff;
  logic [3:0]            op_be_ff;
  logic                  cfg_ack_ff, mem_hit_ff, op_req_ff, op_we_ff, mem_rvalid_ff, swap_en_ff, load_done_ff;
  int                    mismatches, compares;
  localparam logic [31:0] F = 32'hffff_ffff;
  pch_row_t rows [17] = '{'{1'h1, 6'h03, F, 32'h0}, '{1'h0, 6'h03, F, 32'h0000_ff00},
    '{1'h1, 6'h04, F, 32'h0}, '{1'h0, 6'h04, 32'h0, 32'hffff_f000}, '{1'h1, 6'h0b, F, 32'h0},
    '{1'h0, 6'h0b, 32'h0, 32'h2468_1357}, '{1'h1, 6'h0c, F, 32'h0}, '{1'h0, 6'h0c, 32'h0, 32'h0},
    '{1'h1, 6'h0d, F, 32'h0}, '{1'h0, 6'h0d, 32'h0, 32'h60}, '{1'h1, 6'h0f, F, 32'h0},
    '{1'h0, 6'h0f, 32'h0, 32'h3412_01ff}, '{1'h1, 6'h10, F, 32'h0}, '{1'h0, 6'h10, 32'h0, 32'h1},
    '{1'h1, 6'h05, F, 32'h0}, '{1'h0, 6'h05, 32'h0, 32'h0}, '{1'h0, 6'h0e, 32'h0, 32'h0}};

  pch_cfg_regs u_dut (.*);
  pch_op_model u_model (.*);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cfg(input logic w, input logic [5:0] d, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    #1 cfg_req = '{1'h1, w, d, 4'hf, wd};
    @(posedge clk);
    #1 cfg_req = '0;
    chk(cfg_ack_ff, 32'h1);
    rd = cfg_rdata_ff;
  endtask

  task automatic mem(input logic w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] wd,
                     input logic h, input logic [31:0] ex);
    @(posedge clk);
    #1 mem_req = '{1'h1, w, a, be, wd};
    @(posedge clk);
    #1 mem_req = '0;
    chk(mem_hit_ff, h);
    if (h && w) chk(op_wdata_ff, ex);
    if (h && !w) begin
      repeat (20) if (mem_rvalid_ff !== 1'h1) begin @(posedge clk); #1; end
      chk(mem_rvalid_ff, 32'h1);
      chk(mem_rdata_ff, ex);
    end
  endtask

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  initial begin
    {resetn, load_valid, slow, cfg_req, mem_req, load_data} = '0;
    repeat (8) @(posedge clk);
    #1 resetn = 1'h1;
    @(posedge clk);
    #1 load_valid = 1'h1;
    load_data = '{16'h1357, 16'h2468, 8'h12, 8'h34};
    @(posedge clk);
    // A second load after the first must be ignored
    #1 load_data = '{16'h9999, 16'h8888, 8'h77, 8'h66};
    @(posedge clk);
    #1 load_valid = 1'h0;
    repeat (2) @(posedge clk);
    chk(load_done_ff, 32'h1);
    foreach (rows[i]) begin
      cfg(rows[i].we, rows[i].dw, rows[i].wd, r);
      chk(r, rows[i].ex);
    end
    chk({bus_hold_limit_ff, irq_routing_line_ff, swap_en_ff}, {8'hff, 8'hff, 1'h1});
    cfg(1'h0, 6'h0f, 32'h0, r);
    chk(r, 32'h3412_01ff);
    cfg(1'h1, 6'h04, 32'h0001_2345, r);
    mem(1'h1, 32'h0001_2008, 4'h1, 32'haabb_ccdd, 1'h1, 32'hddcc_bbaa);
    chk(op_be_ff, 32'h8);
    mem(1'h0, 32'h0001_2008, 4'hf, 32'h0, 1'h1, 32'h0000_00dd);
    cfg(1'h1, 6'h10, 32'h0, r);
    slow = 1'h1;
    mem(1'h0, 32'h0001_2008, 4'hf, 32'h0, 1'h1, 32'hdd00_0000);
    slow = 1'h0;
    mem(1'h1, 32'h0001_2ffc, 4'hf, 32'h1122_3344, 1'h1, 32'h1122_3344);
    mem(1'h1, 32'h0001_3000, 4'hf, 32'h0, 1'h0, 32'h0);
    mem(1'h0, 32'h0001_1ffc, 4'hf, 32'h0, 1'h0, 32'h0);
    @(posedge clk);
    #1 resetn = 1'h0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'h1;
    chk({bus_hold_limit_ff, irq_routing_line_ff, swap_en_ff}, 32'h0);
    cfg(1'h0, 6'h0f, 32'h0, r);
    chk(r, 32'h0000_0100);
    cfg(1'h0, 6'h04, 32'h0, r);
    chk(r, 32'h0);
    mem(1'h0, 32'h0000_0018, 4'hf, 32'h0, 1'h1, 32'hdd00_0000);
    complete_run();
  end
endmodule
